// file: design/event_ctrl_pkg.sv
// constants and carrier types for the two stage event controller
package event_ctrl_pkg;
    localparam int NUM_SRC   = 32;
    localparam int NUM_CLASS = 16;
    localparam int NUM_LVL   = 9;
    localparam int FIRST_GP  = 7;
    localparam int NUM_FIXED = 7;
    localparam int MASKABLE0 = 5;
    localparam int ASG_W     = 4;
    localparam int ASG_PER   = 8;
    localparam int NUM_ASG   = 4;
    localparam int AW        = 8;
    // register byte offsets
    localparam logic [7:0] OFF_LATCH  = 8'h00;
    localparam logic [7:0] OFF_MASK   = 8'h04;
    localparam logic [7:0] OFF_ACTIVE = 8'h08;
    localparam logic [7:0] OFF_GIE    = 8'h0c;
    localparam logic [7:0] OFF_SMASK  = 8'h10;
    localparam logic [7:0] OFF_SSTAT  = 8'h14;
    localparam logic [7:0] OFF_WAKE   = 8'h18;
    localparam logic [7:0] OFF_ASG0   = 8'h20;
    // reset values
    localparam logic [15:0] RST_CORE16 = 16'h0000;
    localparam logic [31:0] RST_WORD   = 32'h0000_0000;
    localparam logic [31:0] RST_ASG0   = 32'h0000_0000;
    localparam logic [31:0] RST_ASG1   = 32'h3332_2221;
    localparam logic [31:0] RST_ASG2   = 32'h5544_4443;
    localparam logic [31:0] RST_ASG3   = 32'h6660_0005;
    localparam logic [4:0]  NONE_CLASS = 5'h10;
    // carriers
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [2:0]  pprot;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;
    typedef enum logic {SVC_IDLE, SVC_OFFER} svc_state_t;
endpackage

// file: design/two_stage_event_controller.sv
// two stage event controller: source routing stage and core event stage
`timescale 1ns/1ps
`default_nettype none
module two_stage_event_controller #(
    parameter int N_SRC = event_ctrl_pkg::NUM_SRC
) (
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire event_ctrl_pkg::apb_req_t apb_req,
    output var  event_ctrl_pkg::apb_rsp_t apb_rsp,
    input  wire logic [N_SRC-1:0]         src_irq,
    input  wire logic [6:0]               fixed_event,
    input  wire logic                     irq_on_instr,
    input  wire logic                     irq_off_instr,
    input  wire logic                     svc_accept,
    input  wire logic                     svc_return,
    input  wire logic                     core_idle,
    output logic                          svc_req,
    output logic [3:0]                    svc_class,
    output logic [15:0]                   active,
    output logic                          wake
);
    // lowest set bit index, NONE_CLASS when empty
    function automatic logic [4:0] first_set(input logic [15:0] v);
        logic [4:0] r;
        r = event_ctrl_pkg::NONE_CLASS;
        for (int i = 15; i >= 0; i--)
        begin
            if (v[i])
                r = 5'(i);
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // register state
    logic [15:0]      latch_q;
    logic [15:0]      mask_q;
    logic [15:0]      active_q;
    logic             gie_q;
    logic [N_SRC-1:0] smask_q;
    logic [N_SRC-1:0] wake_en_q;
    logic [15:0]      sw_sel;
    logic [31:0]      asg_q [event_ctrl_pkg::NUM_ASG];
    logic [N_SRC-1:0] src_q1;
    logic [N_SRC-1:0] src_q2;
    logic [8:0]       lvl_d;
    logic [8:0]       lvl_q;
    logic [8:0]       lvl_prev_q;
    logic [8:0]       gp_edge;
    logic [15:0]      set_vec;
    logic [15:0]      enable;
    logic [4:0]       cand;
    logic [4:0]       cur;
    logic             ack_fire;
    logic [15:0]      ack_vec;
    logic [15:0]      rtn_vec;
    event_ctrl_pkg::svc_state_t svc_state_q;
    logic             svc_req_q;
    logic [3:0]       svc_class_q;
    logic             wake_q;
    event_ctrl_pkg::apb_rsp_t rsp_q;

    ////////////////////////////////////////////////////////////////////
    // apb decode
    logic       acc;
    logic       wr_fire;
    logic       priv;
    logic       core_reg;
    logic       bad;
    logic [7:0] addr;
    logic [2:0] asg_idx;
    logic [7:0] asg_off;
    logic       asg_hit;
    logic [31:0] rd_val;

    assign acc      = apb_req.psel && apb_req.penable;
    assign wr_fire  = acc && rsp_q.pready && apb_req.pwrite && !rsp_q.pslverr;
    assign priv     = apb_req.pprot[0];
    assign addr     = apb_req.paddr;
    assign asg_off  = addr - event_ctrl_pkg::OFF_ASG0;
    assign asg_idx  = 3'(asg_off >> 2);
    // bounded window: no alias of higher offsets onto the assignment registers
    assign asg_hit  = (addr >= event_ctrl_pkg::OFF_ASG0) && (asg_off < 8'(event_ctrl_pkg::NUM_ASG * 4))
                      && (addr[1:0] == 2'b00);
    assign core_reg = (addr == event_ctrl_pkg::OFF_MASK) || (addr == event_ctrl_pkg::OFF_ACTIVE);

    always_comb
    begin
        rd_val = event_ctrl_pkg::RST_WORD;
        bad    = 1'b0;
        case (addr)
            event_ctrl_pkg::OFF_LATCH:  rd_val = {16'h0000, latch_q};
            event_ctrl_pkg::OFF_MASK:   rd_val = {16'h0000, mask_q};
            event_ctrl_pkg::OFF_ACTIVE: rd_val = {16'h0000, active_q};
            event_ctrl_pkg::OFF_GIE:    rd_val = {31'h0000_0000, gie_q};
            event_ctrl_pkg::OFF_SMASK:  rd_val = 32'(smask_q);
            event_ctrl_pkg::OFF_SSTAT:  rd_val = 32'(src_q2);
            event_ctrl_pkg::OFF_WAKE:   rd_val = 32'(wake_en_q);
            default:
            begin
                if (asg_hit)
                    rd_val = asg_q[asg_idx[1:0]];
                else
                    bad = 1'b1;
            end
        endcase
        if (core_reg && !priv)
            bad = 1'b1;
        if (!bad && apb_req.pwrite && (addr == event_ctrl_pkg::OFF_ACTIVE ||
            addr == event_ctrl_pkg::OFF_SSTAT || addr == event_ctrl_pkg::OFF_GIE))
            bad = 1'b1;
    end

    // one wait state per transfer
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rsp_q <= '0;
        else if (acc && !rsp_q.pready)
        begin
            rsp_q.pready  <= 1'b1;
            rsp_q.pslverr <= bad;
            rsp_q.prdata  <= (bad || apb_req.pwrite) ? event_ctrl_pkg::RST_WORD : rd_val;
        end
        else
            rsp_q <= '0;
    end
    assign apb_rsp = rsp_q;

    ////////////////////////////////////////////////////////////////////
    // routing stage
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            src_q1 <= '0;
            src_q2 <= '0;
        end
        else
        begin
            src_q1 <= src_irq;
            src_q2 <= src_q1;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            smask_q   <= '0;
            wake_en_q <= '0;
            asg_q[0]  <= event_ctrl_pkg::RST_ASG0;
            asg_q[1]  <= event_ctrl_pkg::RST_ASG1;
            asg_q[2]  <= event_ctrl_pkg::RST_ASG2;
            asg_q[3]  <= event_ctrl_pkg::RST_ASG3;
        end
        else if (wr_fire)
        begin
            if (addr == event_ctrl_pkg::OFF_SMASK)
                smask_q <= apb_req.pwdata[N_SRC-1:0];
            if (addr == event_ctrl_pkg::OFF_WAKE)
                wake_en_q <= apb_req.pwdata[N_SRC-1:0];
            if (asg_hit)
                asg_q[asg_idx[1:0]] <= apb_req.pwdata;
        end
    end

    // level drive from unmasked assigned sources
    always_comb
    begin
        logic [3:0] id;
        id    = 4'h0;
        lvl_d = '0;
        for (int s = 0; s < N_SRC; s++)
        begin
            id = asg_q[s / event_ctrl_pkg::ASG_PER][(s % event_ctrl_pkg::ASG_PER) * 4 +: 4];
            if (src_q2[s] && smask_q[s] && id < 4'(event_ctrl_pkg::NUM_LVL))
                lvl_d[id] = 1'b1;
        end
    end

    // wake while idle, released once a class 7 to 15 event is active
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            wake_q <= 1'b0;
        else
            wake_q <= core_idle && |(src_q2 & wake_en_q) && !(|active_q[15:7]);
    end

    ////////////////////////////////////////////////////////////////////
    // core stage: edge detect over two cycles
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lvl_q      <= '0;
            lvl_prev_q <= '0;
        end
        else
        begin
            lvl_q      <= lvl_d;
            lvl_prev_q <= lvl_q;
        end
    end
    assign gp_edge = lvl_q & ~lvl_prev_q;
    assign set_vec = {gp_edge, fixed_event};

    assign ack_fire = svc_req_q && svc_accept;
    assign ack_vec  = ack_fire ? (16'h0001 << svc_class_q) : 16'h0000;
    assign cur      = first_set(active_q);
    assign rtn_vec  = (svc_return && cur != event_ctrl_pkg::NONE_CLASS) ? (16'h0001 << cur[3:0]) : 16'h0000;

    // latch: software writes only masked bits, hardware set wins
    assign sw_sel = (wr_fire && addr == event_ctrl_pkg::OFF_LATCH) ? ~mask_q : 16'h0000;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            latch_q <= event_ctrl_pkg::RST_CORE16;
        else
            latch_q <= (((latch_q & ~sw_sel) | (apb_req.pwdata[15:0] & sw_sel)) & ~ack_vec)
                       | set_vec;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            mask_q <= event_ctrl_pkg::RST_CORE16;
        else if (wr_fire && addr == event_ctrl_pkg::OFF_MASK)
            mask_q <= apb_req.pwdata[15:0];
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            gie_q <= 1'b0;
        else if (irq_on_instr)
            gie_q <= 1'b1;
        else if (irq_off_instr)
            gie_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            active_q <= event_ctrl_pkg::RST_CORE16;
        else
            active_q <= (active_q & ~rtn_vec) | ack_vec;
    end

    // classes below MASKABLE0 are never masked
    always_comb
    begin
        enable = mask_q;
        enable[event_ctrl_pkg::MASKABLE0-1:0] = '1;
        if (!gie_q)
            enable[15:7] = '0;
    end
    assign cand = first_set(latch_q & enable);

    // offer of the best event to the sequencer
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            svc_state_q <= event_ctrl_pkg::SVC_IDLE;
            svc_req_q   <= 1'b0;
            svc_class_q <= 4'h0;
        end
        else
        begin
            case (svc_state_q)
                event_ctrl_pkg::SVC_IDLE:
                begin
                    if (cand != event_ctrl_pkg::NONE_CLASS && cand < cur)
                    begin
                        svc_state_q <= event_ctrl_pkg::SVC_OFFER;
                        svc_req_q   <= 1'b1;
                        svc_class_q <= cand[3:0];
                    end
                end
                event_ctrl_pkg::SVC_OFFER:
                begin
                    if (ack_fire || !(latch_q[svc_class_q] && enable[svc_class_q]))
                    begin
                        svc_state_q <= event_ctrl_pkg::SVC_IDLE;
                        svc_req_q   <= 1'b0;
                    end
                end
                default:
                begin
                    svc_state_q <= event_ctrl_pkg::SVC_IDLE;
                    svc_req_q   <= 1'b0;
                end
            endcase
        end
    end

    assign svc_req   = svc_req_q;
    assign svc_class = svc_class_q;
    assign active    = active_q;
    assign wake      = wake_q;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_offer;
        svc_req_q && svc_accept;
    endsequence

    chk_accept_active: assert property (s_offer |=> active_q[$past(svc_class_q)])
        else $error("accepted event not active");
    chk_accept_clear: assert property (s_offer ##1 !$past(set_vec[svc_class_q])
        |-> !latch_q[$past(svc_class_q)])
        else $error("latch not cleared on accept");
    chk_edge_latch: assert property ((|gp_edge) |=> ((latch_q[15:7] & $past(gp_edge)) == $past(gp_edge)))
        else $error("edge not latched");
    chk_edge_latency: assert property ((|(gp_edge & ~active_q[15:7]))
        |=> ((active_q[15:7] & $past(gp_edge & ~active_q[15:7])) == 9'h000))
        else $error("active too soon after edge");
    chk_offer_masked: assert property (svc_req_q |-> enable[svc_class_q] || $past(ack_fire))
        else $error("masked event offered");
    chk_gie_block: assert property ($rose(svc_req_q) |-> (gie_q || svc_class_q < 4'h7))
        else $error("general level offered while disabled");
    chk_nest_prio: assert property ($rose(svc_req_q) |-> {1'b0, svc_class_q} < cur)
        else $error("offer does not preempt");
    chk_mask_priv: assert property (acc && !priv && addr == event_ctrl_pkg::OFF_MASK
        |=> ##1 $stable(mask_q))
        else $error("mask changed outside supervisor");
    chk_wake_idle: assert property (core_idle && |(src_q2 & wake_en_q) && !(|active_q[15:7])
        |=> wake_q)
        else $error("wake missing");
    chk_level_route: assert property (lvl_q == $past(lvl_d))
        else $error("level register stale");

    // register access, return and source mask checks
    chk_latch_masked: assert property (wr_fire && addr == event_ctrl_pkg::OFF_LATCH
        |=> (((latch_q ^ $past(latch_q)) & $past(mask_q) & ~$past(set_vec | ack_vec)) == 16'h0000))
        else $error("latch bit changed under set mask");
    chk_return_clear: assert property (svc_return && cur != event_ctrl_pkg::NONE_CLASS
        |=> !active_q[$past(cur[3:0])])
        else $error("returned event still active");
    chk_level_source: assert property ((|lvl_q)
        |-> $past(|(src_q2 & smask_q)))
        else $error("level raised by masked source");
endmodule
`default_nettype wire

// file: testbench/seq_model.sv
// sequencer model that accepts offered events after a set delay
`timescale 1ns/1ps
`default_nettype none
module seq_model (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       svc_req,
    input  wire logic [3:0] delay,
    output logic            svc_accept
);
    logic [3:0] wait_q;
    // accept pulse only while an offer stands, after delay idle cycles
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wait_q     <= 4'h0;
            svc_accept <= 1'h0;
        end
        else if (!svc_req || svc_accept)
        begin
            wait_q     <= 4'h0;
            svc_accept <= 1'h0;
        end
        else if (wait_q == delay)
            svc_accept <= 1'h1;
        else
            wait_q <= wait_q + 4'h1;
    end
endmodule
`default_nettype wire

// file: testbench/tb_two_stage_event_controller.sv
// self-checking bench for the two stage event controller
`timescale 1ns/1ps
`default_nettype none
module tb_two_stage_event_controller;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic                     clk;
    logic                     reset_n;
    event_ctrl_pkg::apb_req_t req;
    event_ctrl_pkg::apb_rsp_t rsp;
    logic [31:0]              src_irq;
    logic [6:0]               fixed_event;
    logic                     irq_on;
    logic                     irq_off;
    logic                     svc_accept;
    logic                     svc_return;
    logic                     core_idle;
    logic                     svc_req;
    logic [3:0]               svc_class;
    logic [15:0]              active;
    logic                     wake;
    logic [3:0]               delay;
    logic [31:0]              w;
    int                       fail_count;
    int                       checks;
    int                       n;
    wire logic [17:0]         obs = {wake, svc_req, active};

    two_stage_event_controller u_two_stage_event_controller (
        .clk(clk), .reset_n(reset_n), .apb_req(req), .apb_rsp(rsp), .src_irq(src_irq),
        .fixed_event(fixed_event), .irq_on_instr(irq_on), .irq_off_instr(irq_off),
        .svc_accept(svc_accept), .svc_return(svc_return), .core_idle(core_idle),
        .svc_req(svc_req), .svc_class(svc_class), .active(active), .wake(wake)
    );
    seq_model u_seq_model (
        .clk(clk), .reset_n(reset_n), .svc_req(svc_req), .delay(delay), .svc_accept(svc_accept)
    );
    always #12.5 clk = ~clk;
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wait_for(input int b, input logic v);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (obs[b] !== v && n < 40);
        if (obs[b] !== v)
        begin
            fail_count++;
            end_of_test;
        end
    endtask
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic sup, input logic e);
        int k;
        @(posedge clk);
        req <= '{1'h1, 1'h0, wr, {2'h0, sup}, a, d};
        @(posedge clk);
        req.penable <= 1'h1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (rsp.pready !== 1'h1 && k < 20);
        if (rsp.pready !== 1'h1)
        begin
            fail_count++;
            end_of_test;
        end
        chk($sformatf("error flag at %h", a), 32'(rsp.pslverr), 32'(e));
        if (!wr)
            chk($sformatf("read data at %h", a), rsp.prdata & m, d & m);
        req.psel <= 1'h0;
        req.penable <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        acc(1'h0, a, d, m, 1'h1, 1'h0);
    endtask
    task automatic wrt(input logic [7:0] a, input logic [31:0] d);
        acc(1'h1, a, d, ALL, 1'h1, 1'h0);
    endtask
    task automatic ret;
        @(posedge clk);
        svc_return <= 1'h1;
        @(posedge clk);
        svc_return <= 1'h0;
    endtask
    function automatic logic [3:0] dflt(input int s);
        return 4'(s < 8 ? 0 : s < 9 ? 1 : s < 13 ? 2 : s < 17 ? 3 : s < 22 ? 4 : s < 25 ? 5 : s < 29 ? 0 : 6);
    endfunction
    ////////////////////////////////////////
    initial
    begin
        clk = 1'h0;
        reset_n = 1'h0;
        req = '0;
        src_irq = 32'h0000_0000;
        fixed_event = 7'h00;
        irq_on = 1'h0;
        irq_off = 1'h0;
        svc_return = 1'h0;
        core_idle = 1'h0;
        delay = 4'h0;
        fail_count = 0;
        checks = 0;
        repeat (3) @(posedge clk);
        reset_n <= 1'h1;
        rd(event_ctrl_pkg::OFF_LATCH, 32'h0000_0000, ALL);
        rd(event_ctrl_pkg::OFF_MASK, 32'h0000_0000, 32'h0000_ffe0);
        rd(event_ctrl_pkg::OFF_ACTIVE, 32'h0000_0000, ALL);
        rd(event_ctrl_pkg::OFF_SMASK, 32'h0000_0000, ALL);
        rd(event_ctrl_pkg::OFF_WAKE, 32'h0000_0000, ALL);
        for (int r = 0; r < 4; r++)
        begin
            for (int k = 0; k < 8; k++)
                w[k*4 +: 4] = dflt(r * 8 + k);
            rd(8'(event_ctrl_pkg::OFF_ASG0 + 8'(r * 4)), w, ALL);
        end
        acc(1'h0, 8'h30, 32'h0000_0000, ALL, 1'h1, 1'h1);
        acc(1'h1, event_ctrl_pkg::OFF_MASK, 32'h0000_ffe0, ALL, 1'h0, 1'h1);
        acc(1'h0, event_ctrl_pkg::OFF_MASK, 32'h0000_0000, ALL, 1'h0, 1'h1);
        acc(1'h1, event_ctrl_pkg::OFF_ACTIVE, 32'h0000_ffff, ALL, 1'h1, 1'h1);
        rd(event_ctrl_pkg::OFF_MASK, 32'h0000_0000, 32'h0000_ffe0);
        wrt(event_ctrl_pkg::OFF_LATCH, 32'h0000_0100);
        rd(event_ctrl_pkg::OFF_LATCH, 32'h0000_0100, ALL);
        chk("offer while masked", 32'(svc_req), 32'h0000_0000);
        wrt(event_ctrl_pkg::OFF_MASK, 32'h0000_01c0);
        wrt(event_ctrl_pkg::OFF_LATCH, 32'h0000_0000);
        rd(event_ctrl_pkg::OFF_LATCH, 32'h0000_0100, ALL);
        chk("offer while disabled", 32'(svc_req), 32'h0000_0000);
        @(posedge clk) irq_on <= 1'h1;
        @(posedge clk) irq_on <= 1'h0;
        wait_for(16, 1'h1);
        chk("offered class", 32'(svc_class), 32'h0000_0008);
        wait_for(8, 1'h1);
        rd(event_ctrl_pkg::OFF_LATCH, 32'h0000_0000, ALL);
        rd(event_ctrl_pkg::OFF_ACTIVE, 32'h0000_0100, ALL);
        ret;
        wait_for(8, 1'h0);
        delay <= 4'h5;
        wrt(event_ctrl_pkg::OFF_SMASK, 32'h0000_0003);
        @(posedge clk) src_irq[0] <= 1'h1;
        wait_for(7, 1'h1);
        chk("edge to active", 32'(n >= 3), 32'h0000_0001);
        chk("routed level", 32'(active), 32'h0000_0080);
        @(posedge clk) src_irq[0] <= 1'h0;
        repeat (4) @(posedge clk);
        src_irq[1] <= 1'h1;
        repeat (8) @(posedge clk);
        rd(event_ctrl_pkg::OFF_LATCH, 32'h0000_0080, ALL);
        rd(event_ctrl_pkg::OFF_SSTAT, 32'h0000_0002, ALL);
        @(posedge clk) fixed_event[6] <= 1'h1;
        @(posedge clk) fixed_event[6] <= 1'h0;
        wait_for(6, 1'h1);
        chk("nested", 32'(active), 32'h0000_00c0);
        ret;
        wait_for(6, 1'h0);
        chk("return order", 32'(active), 32'h0000_0080);
        ret;
        wait_for(7, 1'h0);
        wait_for(7, 1'h1);
        chk("queued edge", 32'(active), 32'h0000_0080);
        ret;
        wait_for(7, 1'h0);
        src_irq[1] <= 1'h0;
        src_irq[2] <= 1'h1;
        repeat (10) @(posedge clk);
        rd(event_ctrl_pkg::OFF_LATCH, 32'h0000_0000, ALL);
        @(posedge clk) irq_off <= 1'h1;
        @(posedge clk) irq_off <= 1'h0;
        src_irq[0] <= 1'h1;
        repeat (10) @(posedge clk);
        chk("offer after off", 32'(svc_req), 32'h0000_0000);
        rd(event_ctrl_pkg::OFF_LATCH, 32'h0000_0080, ALL);
        wrt(event_ctrl_pkg::OFF_WAKE, 32'h0000_0008);
        core_idle <= 1'h1;
        src_irq[3] <= 1'h1;
        wait_for(17, 1'h1);
        chk("wake lag", 32'(n < 8), 32'h0000_0001);
        @(posedge clk) irq_on <= 1'h1;
        @(posedge clk) irq_on <= 1'h0;
        wait_for(17, 1'h0);
        chk("acknowledge", 32'(active[7]), 32'h0000_0001);
        wrt(event_ctrl_pkg::OFF_ASG0, 32'h0000_0002);
        repeat (2) @(posedge clk);
        rd(event_ctrl_pkg::OFF_LATCH, 32'h0000_0200, ALL);
        end_of_test;
    end
endmodule
`default_nettype wire
